//--- verilog/tsf_top.sv
// temperature sample buffer: indices, counters, byte port, flag
// assumes: serial engine gives one register strobe per byte
//
// Notes on behaviour
// R01: write index steps once per pushed word, wrapping 0x1F to 0x00.
// R02: read index steps once per fully read word, wrapping to zero.
// R03: master may read and overwrite the read index to refetch words.
// R04: words lost to a full buffer are counted, saturating at 0x1F.
// R05: lost-word count returns to zero whenever a whole word is read.
// R06: stored-word count rises per push, falls per whole word read.
// R07: 2N bytes read from the data port pop N words.
// R08: each sample gives its upper byte first, then its lower byte.
// R09: up to 32 words; the count tells empty from full.
// R10: master reads lost count then stored count; nonzero lost means 32.
// R11: flag sets when count reaches 32 minus the watermark setting.
// R12: pin zero signals the flag when enabled and function select is 3.
// R13: rollover on and full: newest sample overwrites the oldest.
// R14: rollover off and full: new sample dropped, buffer unchanged.
// R15: flag style low: flag re-asserts on each sample while condition holds.
// R16: flag style high: flag asserts only on a new condition.
// R17: data-port read clears the flag only when its clear bit is set.
// R18: flush empties the buffer, zeroes indices and counts, self-clears.
// R19: master takes care rewriting the read index; side effects follow.
// R20: read transaction is command 0x33, start address, length minus one.
// R21: sample stored at write index, and the write index steps in that same cycle.
`timescale 1ns/100ps
`default_nettype none

module tsf_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // samples from conversion
   input  wire logic        push_i,
   input  wire logic [15:0] push_data_i,
   // register port from serial engine
   input  wire logic        txn_start_i,
   input  wire logic [7:0]  txn_cmd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_rd_i,
   input  wire logic        reg_wr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic [7:0]       reg_rdata_o,
   output logic             reg_rvalid_o,
   // interrupt routing settings
   input  wire logic        a_full_en_i,
   input  wire logic [1:0]  pin0_function_select_i,
   // flag and pin
   output logic             a_full_o,
   output logic             general_pin_zero_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   tsf_store_if st ();

   logic [4:0]          write_index_q;
   logic [4:0]          write_index_d;
   logic [4:0]          read_index_q;
   logic [4:0]          read_index_d;
   logic [4:0]          lost_word_count_q;
   logic [4:0]          lost_word_count_d;
   logic [5:0]          count_q;
   logic [5:0]          count_d;
   logic [4:0]          wm_q;
   logic                clear_flag_on_data_read_q;
   logic                edge_type_q;
   logic                overwrite_when_full_q;
   logic                flush_pend_q;
   tsf_pkg::tsf_half_t  half_q;
   logic                rd_data;
   logic                rd_status;
   logic                wr_rd_idx;
   logic                wr_ctrl;
   logic                pop;
   logic                full;
   logic                room;
   logic                accept;
   logic                overwrite;
   logic                lost_evt;
   logic [5:0]          thresh;
   logic                flag_clear;
   logic                flag_q;
   logic [7:0]          rbyte;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] t);
      hit = (a == t);
   endfunction : hit

   // ------------------------------------------------------------
   // register strobe decode
   // ------------------------------------------------------------
   assign rd_data   = reg_rd_i && hit(reg_addr_i, tsf_pkg::ADDR_DATA);
   assign rd_status = reg_rd_i && hit(reg_addr_i, tsf_pkg::ADDR_STATUS);
   assign wr_rd_idx = reg_wr_i && hit(reg_addr_i, tsf_pkg::ADDR_RD_IDX);
   assign wr_ctrl   = reg_wr_i && hit(reg_addr_i, tsf_pkg::ADDR_CTRL_CFG);

   // ------------------------------------------------------------
   // byte phase of the data port
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         half_q <= tsf_pkg::TSF_HALF_UPPER;
      end else if (txn_start_i && txn_cmd_i == tsf_pkg::CMD_READ) begin
         half_q <= tsf_pkg::TSF_HALF_UPPER; // see R20
      end else if (flush_pend_q) begin
         half_q <= tsf_pkg::TSF_HALF_UPPER;
      end else if (rd_data) begin
         case (half_q) // see R07
            tsf_pkg::TSF_HALF_UPPER: half_q <= tsf_pkg::TSF_HALF_LOWER;
            tsf_pkg::TSF_HALF_LOWER: half_q <= tsf_pkg::TSF_HALF_UPPER;
            default:                 half_q <= tsf_pkg::TSF_HALF_UPPER;
         endcase
      end
   end

   // ------------------------------------------------------------
   // push and pop decisions
   // ------------------------------------------------------------
   always_comb begin
      full      = (count_q == tsf_pkg::COUNT_FULL); // see R09
      pop       = rd_data && half_q == tsf_pkg::TSF_HALF_LOWER
                  && count_q != 6'h00 && !flush_pend_q; // see R07
      room      = !full || pop;
      accept    = push_i && !flush_pend_q && room; // see R14
      overwrite = push_i && !flush_pend_q && !room
                  && overwrite_when_full_q; // see R13
      lost_evt  = push_i && !flush_pend_q && !room; // see R04
   end

   // ------------------------------------------------------------
   // next index and count values
   // ------------------------------------------------------------
   always_comb begin
      write_index_d     = write_index_q;
      read_index_d      = read_index_q;
      count_d           = count_q;
      lost_word_count_d = lost_word_count_q;
      if (flush_pend_q) begin
         write_index_d     = 5'h00; // see R18
         read_index_d      = 5'h00;
         count_d           = 6'h00;
         lost_word_count_d = 5'h00;
      end else begin
         if (accept || overwrite) begin
            write_index_d = write_index_q + 5'h01; // see R01
         end
         if (wr_rd_idx) begin
            read_index_d = reg_wdata_i[4:0]; // see R03
         end else if (pop || overwrite) begin
            read_index_d = read_index_q + 5'h01; // see R02
         end
         if (accept && !pop) begin
            count_d = count_q + 6'h01; // see R06
         end else if (pop && !accept) begin
            count_d = count_q - 6'h01;
         end
         if (pop) begin
            lost_word_count_d = 5'h00; // see R05
         end else if (lost_evt && lost_word_count_q != tsf_pkg::LOST_MAX) begin
            lost_word_count_d = lost_word_count_q + 5'h01; // see R04
         end
      end
   end

   // ------------------------------------------------------------
   // index and count state
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         write_index_q     <= 5'h00;
         read_index_q      <= 5'h00;
         count_q           <= 6'h00;
         lost_word_count_q <= 5'h00;
      end else begin
         write_index_q     <= write_index_d; // see R21
         read_index_q      <= read_index_d;
         count_q           <= count_d;
         lost_word_count_q <= lost_word_count_d;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wm_q <= tsf_pkg::WM_RST;
      end else if (reg_wr_i && hit(reg_addr_i, tsf_pkg::ADDR_WM_CFG)) begin
         wm_q <= reg_wdata_i[4:0];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clear_flag_on_data_read_q <= 1'b0;
         edge_type_q               <= 1'b0;
         overwrite_when_full_q     <= 1'b0;
      end else if (wr_ctrl) begin
         clear_flag_on_data_read_q <= reg_wdata_i[tsf_pkg::CTRL_STATCLR];
         edge_type_q               <= reg_wdata_i[tsf_pkg::CTRL_TYPE];
         overwrite_when_full_q     <= reg_wdata_i[tsf_pkg::CTRL_RO];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flush_pend_q <= 1'b0;
      end else begin
         flush_pend_q <= wr_ctrl && reg_wdata_i[tsf_pkg::CTRL_FLUSH]; // see R18
      end
   end

   // ------------------------------------------------------------
   // storage and watermark flag
   // ------------------------------------------------------------
   assign st.wr_en   = accept || overwrite; // see R21
   assign st.wr_idx  = write_index_q;
   assign st.wr_data = push_data_i;
   assign st.rd_idx  = read_index_q;

   tsf_store u_store (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .st     (st)
   );

   assign thresh     = tsf_pkg::COUNT_FULL - {1'b0, wm_q}; // see R11
   assign flag_clear = rd_status
                       || (rd_data && clear_flag_on_data_read_q); // see R17

   tsf_flag u_flag (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .sample_i    (push_i && !flush_pend_q),
      .count_nxt_i (count_d),
      .thresh_i    (thresh),
      .edge_type_i (edge_type_q),
      .clear_i     (flag_clear),
      .flag_o      (flag_q)
   );

   assign a_full_o = flag_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         general_pin_zero_o <= 1'b0;
      end else begin
         general_pin_zero_o <= flag_q && a_full_en_i
            && pin0_function_select_i == tsf_pkg::PIN0_FN_IRQ; // see R12
      end
   end

   // ------------------------------------------------------------
   // read data mux
   // ------------------------------------------------------------
   always_comb begin
      case (reg_addr_i)
         tsf_pkg::ADDR_STATUS:
            rbyte = {flag_q, 7'h00};
         tsf_pkg::ADDR_WR_IDX:   rbyte = {3'h0, write_index_q};
         tsf_pkg::ADDR_RD_IDX:   rbyte = {3'h0, read_index_q};
         tsf_pkg::ADDR_LOST:     rbyte = {3'h0, lost_word_count_q};
         tsf_pkg::ADDR_COUNT:    rbyte = {2'h0, count_q};
         tsf_pkg::ADDR_DATA: begin
            if (half_q == tsf_pkg::TSF_HALF_UPPER) begin
               rbyte = st.rd_data[15:8]; // see R08
            end else begin
               rbyte = st.rd_data[7:0];
            end
         end
         tsf_pkg::ADDR_WM_CFG:   rbyte = {3'h0, wm_q};
         tsf_pkg::ADDR_CTRL_CFG:
            rbyte = {3'h0, flush_pend_q, clear_flag_on_data_read_q,
                     edge_type_q, overwrite_when_full_q, 1'b0};
         default:                rbyte = tsf_pkg::BYTE_ZERO;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o  <= tsf_pkg::BYTE_ZERO;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rbyte;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   wr_index_step_a: assert property ( // see R01
      push_i && !flush_pend_q && (!full || pop || overwrite_when_full_q)
      |=> write_index_q == $past(write_index_q) + 5'h01)
      else $error("write index did not step on push");

   rd_index_pop_a: assert property ( // see R02
      rd_data && half_q == tsf_pkg::TSF_HALF_LOWER && count_q != 6'h00
      && !wr_rd_idx && !flush_pend_q
      |=> read_index_q == $past(read_index_q) + 5'h01)
      else $error("read index did not step on word read");

   rd_index_write_a: assert property ( // see R03
      wr_rd_idx && !flush_pend_q
      |=> read_index_q == $past(reg_wdata_i[4:0]))
      else $error("read index write not taken");

   lost_saturate_a: assert property ( // see R04
      lost_word_count_q == tsf_pkg::LOST_MAX && !flush_pend_q
      && !pop |=> lost_word_count_q == tsf_pkg::LOST_MAX)
      else $error("lost count left saturation");

   lost_clear_a: assert property ( // see R05
      pop |=> lost_word_count_q == 5'h00)
      else $error("lost count not cleared by word read");

   burst_pair_a: assert property ( // see R07
      rd_data && half_q == tsf_pkg::TSF_HALF_UPPER && !flush_pend_q
      && !wr_rd_idx && !(txn_start_i && txn_cmd_i == tsf_pkg::CMD_READ)
      |=> read_index_q - $past(read_index_q) == 5'($past(overwrite)))
      else $error("upper byte moved the read index");

   byte_order_a: assert property ( // see R08
      rd_data && half_q == tsf_pkg::TSF_HALF_UPPER
      |=> reg_rvalid_o && reg_rdata_o == $past(st.rd_data[15:8]))
      else $error("upper byte not delivered first");

   count_bound_a: assert property ( // see R09
      count_q <= tsf_pkg::COUNT_FULL)
      else $error("stored count above depth");

   overwrite_full_a: assert property ( // see R13
      push_i && full && !pop && overwrite_when_full_q && !flush_pend_q
      && !wr_rd_idx
      |=> count_q == tsf_pkg::COUNT_FULL
          && read_index_q == $past(read_index_q) + 5'h01)
      else $error("rollover did not drop the oldest word");

   drop_full_a: assert property ( // see R14
      push_i && full && !pop && !overwrite_when_full_q && !flush_pend_q
      |=> $stable(write_index_q) && count_q == tsf_pkg::COUNT_FULL)
      else $error("sample stored while full without rollover");

   status_clear_a: assert property ( // see R17
      rd_status && !push_i && !flush_pend_q && !wr_ctrl
      && !reg_wr_i |=> !a_full_o)
      else $error("status read did not clear the flag");

   pin_route_a: assert property ( // see R12
      ##1 general_pin_zero_o == $past(flag_q && a_full_en_i
          && pin0_function_select_i == tsf_pkg::PIN0_FN_IRQ))
      else $error("pin zero does not follow flag routing");

   flush_all_a: assert property ( // see R18
      wr_ctrl && reg_wdata_i[tsf_pkg::CTRL_FLUSH]
      |=> flush_pend_q ##1 (!flush_pend_q && count_q == 6'h00
          && write_index_q == 5'h00 && read_index_q == 5'h00
          && lost_word_count_q == 5'h00))
      else $error("flush did not empty the buffer");

   rollover_seen_c: cover property (
      push_i && full && overwrite_when_full_q ##1 rd_data);
   flush_seen_c: cover property (full ##[1:40] flush_pend_q);
   pin_seen_c: cover property (
      $rose(general_pin_zero_o) ##[1:20] rd_status);

endmodule : tsf_top

`default_nettype wire

//--- verilog/tsf_pkg.sv
// temperature sample buffer: shared constants, field layout, types
// assumes: one clock domain, byte-wide register port
`default_nettype none

package tsf_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int unsigned DEPTH  = 32;
   localparam int unsigned IDX_W  = 5;
   localparam int unsigned CNT_W  = 6;
   localparam int unsigned WORD_W = 16;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_WR_IDX   = 8'h04;
   localparam logic [7:0] ADDR_RD_IDX   = 8'h05;
   localparam logic [7:0] ADDR_LOST     = 8'h06;
   localparam logic [7:0] ADDR_COUNT    = 8'h07;
   localparam logic [7:0] ADDR_DATA     = 8'h08;
   localparam logic [7:0] ADDR_WM_CFG   = 8'h09;
   localparam logic [7:0] ADDR_CTRL_CFG = 8'h0A;

   // ------------------------------------------------------------
   // fields, commands, reset values
   // ------------------------------------------------------------
   localparam int unsigned STAT_FLAG_BIT = 7;
   localparam int unsigned CTRL_FLUSH    = 4;
   localparam int unsigned CTRL_STATCLR  = 3;
   localparam int unsigned CTRL_TYPE     = 2;
   localparam int unsigned CTRL_RO       = 1;
   localparam logic [7:0]  CMD_READ      = 8'h33;
   localparam logic [1:0]  PIN0_FN_IRQ   = 2'h3;
   localparam logic [4:0]  IDX_MAX       = 5'h1F;
   localparam logic [4:0]  LOST_MAX      = 5'h1F;
   localparam logic [5:0]  COUNT_FULL    = 6'h20;
   localparam logic [4:0]  WM_RST        = 5'h00;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;

   typedef enum logic {
      TSF_HALF_UPPER,
      TSF_HALF_LOWER
   } tsf_half_t;

endpackage : tsf_pkg

`default_nettype wire

//--- verilog/tsf_store_if.sv
// storage access bundle between buffer control and sample storage
// assumes: combinational read, write on the clock edge
`timescale 1ns/100ps
`default_nettype none

interface tsf_store_if;
   logic                          wr_en;
   logic [tsf_pkg::IDX_W-1:0]     wr_idx;
   logic [tsf_pkg::WORD_W-1:0]    wr_data;
   logic [tsf_pkg::IDX_W-1:0]     rd_idx;
   logic [tsf_pkg::WORD_W-1:0]    rd_data;

   modport ctrl (output wr_en, output wr_idx, output wr_data,
                 output rd_idx, input rd_data);
   modport mem  (input wr_en, input wr_idx, input wr_data,
                 input rd_idx, output rd_data);
endinterface : tsf_store_if

`default_nettype wire

//--- verilog/tsf_store.sv
// sample storage: flip-flop array addressed by index
// assumes: control side presents index and data in one cycle
`timescale 1ns/100ps
`default_nettype none

module tsf_store (
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rstn_i,
   // storage access
   tsf_store_if.mem   st
);
   logic [tsf_pkg::WORD_W-1:0] mem_q [tsf_pkg::DEPTH];

   // ------------------------------------------------------------
   // one write port per entry
   // ------------------------------------------------------------
   for (genvar i = 0; i < tsf_pkg::DEPTH; i++) begin : g_ent
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            mem_q[i] <= '0;
         end else if (st.wr_en && int'(st.wr_idx) == i) begin
            mem_q[i] <= st.wr_data; // see R21
         end
      end
   end

   assign st.rd_data = mem_q[st.rd_idx];

endmodule : tsf_store

`default_nettype wire

//--- verilog/tsf_flag.sv
// watermark flag: set on sample events (level style) or on a new condition (edge style), cleared by status reads
// assumes: count_nxt_i is the stored-word count after this cycle
`timescale 1ns/100ps
`default_nettype none

module tsf_flag (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // events and settings
   input  wire logic        sample_i,
   input  wire logic [5:0]  count_nxt_i,
   input  wire logic [5:0]  thresh_i,
   input  wire logic        edge_type_i,
   input  wire logic        clear_i,
   // flag
   output logic             flag_o
);
   logic cond_d;
   logic cond_q;
   logic set_d;

   // ------------------------------------------------------------
   // detection
   // ------------------------------------------------------------
   always_comb begin
      cond_d = (count_nxt_i >= thresh_i); // see R11
      if (edge_type_i) begin
         set_d = cond_d && !cond_q; // see R16
      end else begin
         set_d = sample_i && cond_d; // see R15
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cond_q <= 1'b0;
      end else begin
         cond_q <= cond_d;
      end
   end

   // ------------------------------------------------------------
   // flag, set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else if (set_d) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0; // see R17
      end
   end

endmodule : tsf_flag

`default_nettype wire

//--- sim/tsf_master_model.sv
// bus master model: byte reads and writes on the register port
// assumes: one strobe per byte, read answer one cycle later
`timescale 1ns/100ps
`default_nettype none

module tsf_master_model (
   // clock
   input  wire logic       clk_i,
   // register port
   output logic            txn_start_o,
   output logic [7:0]      txn_cmd_o,
   output logic [7:0]      reg_addr_o,
   output logic            reg_rd_o,
   output logic            reg_wr_o,
   output logic [7:0]      reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);
   logic [7:0] q[$];
   logic       bad_valid;

   initial begin
      txn_start_o = 1'b0;
      txn_cmd_o   = 8'h00;
      reg_addr_o  = 8'hFF;
      reg_rd_o    = 1'b0;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      bad_valid   = 1'b0;
   end

   // read transaction: command, start address, then n byte reads
   task automatic burst(input logic [7:0] a, input int n);
      @(posedge clk_i);
      txn_start_o <= 1'b1;
      txn_cmd_o   <= 8'h33;
      reg_addr_o  <= a;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         txn_start_o <= 1'b0;
         reg_rd_o    <= 1'b1;
         @(posedge clk_i);
         reg_rd_o    <= 1'b0;
         @(posedge clk_i);
         q.push_back(reg_rdata_i);
         if (reg_rvalid_i !== 1'b1)
            bad_valid = 1'b1;
      end
      reg_addr_o <= ~a;
   endtask : burst

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~d;
   endtask : wreg
endmodule : tsf_master_model

`default_nettype wire

//--- sim/test_temperature_sample_fifo.sv
// bench: sample buffer driven through the master model
// assumes: tsf_top and tsf_master_model compiled first
`timescale 1ns/100ps
`default_nettype none

module test_temperature_sample_fifo;
   logic        clk_i, rstn_i, push_i, en, a_full, pin0;
   logic        start, rd, wr, rvalid;
   logic [15:0] push_data_i;
   logic [1:0]  sel;
   logic [7:0]  cmd, addr, wdata, rdata;
   int          miscompares = 0;
   int          check_count = 0;

   tsf_top tsf_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .push_i(push_i),
      .push_data_i(push_data_i), .txn_start_i(start), .txn_cmd_i(cmd),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .a_full_en_i(en), .pin0_function_select_i(sel),
      .a_full_o(a_full), .general_pin_zero_o(pin0));
   tsf_master_model tsf_master_model_i (.clk_i(clk_i),
      .txn_start_o(start), .txn_cmd_o(cmd), .reg_addr_o(addr),
      .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   function automatic logic [15:0] smp(input int n);
      return {8'(8'hA0 + n), 8'(8'h50 + n)};
   endfunction : smp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      tsf_master_model_i.burst(a, 1);
      chk(tsf_master_model_i.q.pop_front(), exp);
   endtask : rchk

   task automatic fchk(input logic e);
      @(negedge clk_i);
      chk({7'h00, a_full}, {7'h00, e});
   endtask : fchk

   task automatic push(input int n);
      @(posedge clk_i);
      push_i      <= 1'b1;
      push_data_i <= smp(n);
      @(posedge clk_i);
      push_i      <= 1'b0;
      push_data_i <= ~smp(n);
   endtask : push

   // burst of n words from the data port, expecting samples first..
   task automatic words(input int first, input int n);
      logic [15:0] w;
      tsf_master_model_i.burst(8'h08, 2 * n);
      for (int i = first; i < first + n; i++) begin
         w = smp(i);
         chk(tsf_master_model_i.q.pop_front(), w[15:8]);
         chk(tsf_master_model_i.q.pop_front(), w[7:0]);
      end
   endtask : words

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rstn_i      = 1'b0;
      push_i      = 1'b0;
      push_data_i = 16'h0000;
      en          = 1'b0;
      sel         = 2'h0;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int a = 4; a <= 10; a++)
         rchk(8'(a), 8'h00);
      rchk(8'h0F, 8'h00);
      for (int n = 0; n < 3; n++)
         push(n);
      rchk(8'h04, 8'h03);
      rchk(8'h07, 8'h03);
      words(0, 2);
      rchk(8'h05, 8'h02);
      rchk(8'h07, 8'h01);
      tsf_master_model_i.wreg(8'h05, 8'h00);
      words(0, 1);
      rchk(8'h05, 8'h01);
      tsf_master_model_i.wreg(8'h0A, 8'h10);
      rchk(8'h0A, 8'h00);
      for (int a = 4; a <= 7; a++)
         rchk(8'(a), 8'h00);
      tsf_master_model_i.wreg(8'h09, 8'h02);
      en  <= 1'b1;
      sel <= 2'h3;
      for (int n = 0; n < 29; n++)
         push(n);
      fchk(1'b0);
      push(29);
      fchk(1'b1);
      @(negedge clk_i);
      chk({7'h00, pin0}, 8'h01);
      @(posedge clk_i);
      sel <= 2'h2;
      repeat (2) @(negedge clk_i);
      chk({7'h00, pin0}, 8'h00);
      rchk(8'h00, 8'h80);
      fchk(1'b0);
      push(30);
      fchk(1'b1);
      push(31);
      rchk(8'h04, 8'h00);
      rchk(8'h07, 8'h20);
      push(32);
      push(33);
      rchk(8'h06, 8'h02);
      rchk(8'h07, 8'h20);
      words(0, 1);
      rchk(8'h06, 8'h00);
      rchk(8'h07, 8'h1F);
      tsf_master_model_i.wreg(8'h0A, 8'h02);
      push(34);
      push(35);
      rchk(8'h06, 8'h01);
      rchk(8'h05, 8'h02);
      words(2, 1);
      rchk(8'h00, 8'h80);
      tsf_master_model_i.wreg(8'h0A, 8'h0C);
      push(36);
      fchk(1'b0);
      tsf_master_model_i.wreg(8'h0A, 8'h08);
      push(37);
      fchk(1'b1);
      words(3, 1);
      fchk(1'b0);
      for (int n = 38; n < 71; n++)
         push(n);
      rchk(8'h06, 8'h1F);
      rchk(8'h07, 8'h20);
      tsf_master_model_i.wreg(8'h0A, 8'h14);
      rchk(8'h07, 8'h00);
      rchk(8'h00, 8'h80);
      for (int n = 0; n < 29; n++)
         push(n);
      fchk(1'b0);
      push(29);
      fchk(1'b1);
      chk({7'h00, tsf_master_model_i.bad_valid}, 8'h00);
      tally_and_finish();
   end
endmodule : test_temperature_sample_fifo

`default_nettype wire
